//--- hw/srbank_pkg.sv
/*
  Shared constants for the status register one shadow bank: command codes,
  register selectors, field positions, factory values and update timing.
  Assumes a 200 MHz core clock; link-side codes arrive as whole bytes.
*/
package srbank_pkg;

  // command codes
  localparam logic [7:0] CMD_REGISTER_WRITE = 8'h01;
  localparam logic [7:0] CMD_GENERIC_READ = 8'h65;
  localparam logic [7:0] CMD_GENERIC_WRITE = 8'h71;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_CLEAR_STATUS_A = 8'h30;
  localparam logic [7:0] CMD_CLEAR_STATUS_B = 8'h82;

  // register selectors for the generic read and write commands
  localparam logic [7:0] ADDR_STATUS_ONE_NV = 8'h00;
  localparam logic [7:0] ADDR_CONFIG_ONE_NV = 8'h02;
  localparam logic [7:0] ADDR_STATUS_ONE_V = 8'h80;
  localparam logic [7:0] ADDR_CONFIG_ONE_V = 8'h82;

  // status register one fields
  localparam int BIT_LOCK = 7;
  localparam int BIT_PERR = 6;
  localparam int BIT_EERR = 5;
  localparam int BP_HI = 4;
  localparam int BP_LO = 2;
  localparam int BIT_WEL = 1;
  localparam int BIT_BUSY = 0;
  // config register one: protect volatility select
  localparam int CFG_BIT_PVS = 3;

  localparam logic [7:0] STATUS_ONE_NV_RESET = 8'h00;
  localparam logic [7:0] CONFIG_ONE_NV_RESET = 8'h00;
  localparam logic [7:0] NV_ERASED = 8'hFF;
  localparam logic [2:0] BP_FORCED = 3'h7;
  localparam logic [2:0] BP_NONE = 3'h0;

  // array operation kinds checked against block protection
  localparam logic [1:0] OP_PROGRAM = 2'h0;
  localparam logic [1:0] OP_SECTOR_ERASE = 2'h1;
  localparam logic [1:0] OP_CHIP_ERASE = 2'h2;

  // non-volatile cell update timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int NV_ERASE_TIME_NS = 50000;
  localparam int NV_PROGRAM_TIME_NS = 50000;
  localparam int NV_ERASE_CYCLES = (NV_ERASE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int NV_PROGRAM_CYCLES =
    (NV_PROGRAM_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 16;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROGRAM = 2'b10,
    ST_REFRESH = 2'b11
  } srbank_state_t;

endpackage

//--- hw/srbank_top.sv
/*
  Status register one bank: non-volatile and volatile copies, register
  commands arriving from the serial link, write-protect lock and block
  protection checks for array operations.
  Assumes the link logic clocks LINK_CLK for as long as it waits for an
  answer, and that the array engine sits on CLOCK.
*/
// Summary of operation
// R1 - registers reached only by dedicated commands
// R2 - keep separate nonvolatile and volatile register copies
// R3 - reads of dual registers return volatile copy
// R4 - any reset reloads volatile from nonvolatile
// R5 - nonvolatile write: erase, program, refresh volatile
// R6 - one-time bit programs only matching volatile bit
// R7 - volatile defaults come from reset values
// R8 - support register, generic read, generic write
// R9 - lock bit plus low pin rejects writes
// R10 - pin high or lock clear allows writes
// R11 - pin affects only status/config one writes
// R12 - volatile bit seven mirrors lock default
// R13 - nonvolatile bit six defaults program error
// R14 - nonvolatile bit five defaults erase error
// R15 - bits one, zero default latch and busy
// R16 - nonvolatile bits four to two protect
// R17 - select zero: nonvolatile protect, copied volatile
// R18 - select one: write updates volatile protect only
// R19 - volatile select forces nonvolatile protect ones
// R20 - protected region refused; chip erase needs zeros
// R21 - writes need latch; only enable/disable change it
// R22 - clear command clears errors, writes do not
// R23 - busy until update and refresh finish
`timescale 1ns/1ps
module srbank_top
  import srbank_pkg::*;
#(
  parameter int ERASE_CYCLES = NV_ERASE_CYCLES,
  parameter int PROGRAM_CYCLES = NV_PROGRAM_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic RESET_REQ,
  input wire logic WP_N,
  input wire logic LINK_CLK,
  input wire logic CMD_STB,
  input wire logic [7:0] CMD_OP,
  input wire logic [7:0] CMD_ADDR,
  input wire logic [15:0] CMD_DATA,
  input wire logic CMD_TWO_BYTES,
  output logic CMD_READY,
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic RSP_OK,
  input wire logic OP_REQ,
  input wire logic [1:0] OP_KIND,
  input wire logic OP_IN_REGION,
  output logic OP_GRANT,
  output logic OP_DENY,
  input wire logic PROG_ERR_EVT,
  input wire logic ERASE_ERR_EVT,
  output logic [2:0] PROTECT_BITS,
  output logic BUSY
);

  function automatic logic [7:0] merge_status(input logic [7:0] old_v, input logic [7:0] wr_v,
                                              input logic vol);
    logic [7:0] r;
    r = old_v;
    r[BIT_LOCK] = wr_v[BIT_LOCK];
    // R19 locked bits
    if (!vol) begin
      r[BP_HI:BP_LO] = wr_v[BP_HI:BP_LO];
    end
    return r;
  endfunction

  function automatic logic [7:0] merge_config(input logic [7:0] old_v, input logic [7:0] wr_v);
    logic [7:0] r;
    r = wr_v;
    // R6 one-time select
    r[CFG_BIT_PVS] = old_v[CFG_BIT_PVS] | wr_v[CFG_BIT_PVS];
    return r;
  endfunction

  // link domain: reset release, command holding, request toggle
  logic link_rst_meta_ff, link_rst_n_ff;
  logic link_req_tgl_ff, ack_meta_ff, ack_sync_ff, ack_seen_ff;
  logic [7:0] link_op_ff, link_addr_ff;
  logic [15:0] link_data_ff;
  logic link_two_ff;
  logic rsp_valid_ff, rsp_ok_link_ff;
  logic [7:0] rsp_data_link_ff;

  // core domain
  logic req_meta_ff, req_sync_ff, req_seen_ff, ack_tgl_ff;
  logic wp_meta_ff, wp_sync_ff;
  logic [7:0] status_one_nonvolatile_ff, config_one_nonvolatile_ff, pend_sr1_ff, pend_cr1_ff, config_one_volatile_ff;
  logic [7:0] rsp_data_ff;
  logic rsp_ok_ff;
  logic lock_copy_ff, perr_ff, eerr_ff, wel_ff, wip_ff;
  logic [2:0] bp_v_ff, protect_ff;
  logic grant_ff, deny_ff;
  srbank_state_t state_ff;
  logic [CNT_W-1:0] cnt_ff;

  always_ff @(posedge LINK_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      link_rst_meta_ff <= 1'b0;
      link_rst_n_ff <= 1'b0;
    end else begin
      link_rst_meta_ff <= 1'b1;
      link_rst_n_ff <= link_rst_meta_ff;
    end
  end

  // one command outstanding; operands stay frozen until its answer returns
  // ready rises with the answer pulse, not one link cycle ahead of it
  assign CMD_READY = link_rst_n_ff && (link_req_tgl_ff == ack_seen_ff);

  always_ff @(posedge LINK_CLK or negedge link_rst_n_ff) begin
    if (!link_rst_n_ff) begin
      link_req_tgl_ff <= 1'b0;
      link_op_ff <= 8'h00;
      link_addr_ff <= 8'h00;
      link_data_ff <= 16'h0000;
      link_two_ff <= 1'b0;
    end else if (CMD_STB && CMD_READY) begin
      link_req_tgl_ff <= ~link_req_tgl_ff;
      link_op_ff <= CMD_OP;
      link_addr_ff <= CMD_ADDR;
      link_data_ff <= CMD_DATA;
      link_two_ff <= CMD_TWO_BYTES;
    end
  end

  always_ff @(posedge LINK_CLK or negedge link_rst_n_ff) begin
    if (!link_rst_n_ff) begin
      ack_meta_ff <= 1'b0;
      ack_sync_ff <= 1'b0;
      ack_seen_ff <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_data_link_ff <= 8'h00;
      rsp_ok_link_ff <= 1'b0;
    end else begin
      ack_meta_ff <= ack_tgl_ff;
      ack_sync_ff <= ack_meta_ff;
      ack_seen_ff <= ack_sync_ff;
      rsp_valid_ff <= ack_sync_ff ^ ack_seen_ff;
      if (ack_sync_ff ^ ack_seen_ff) begin
        rsp_data_link_ff <= rsp_data_ff;
        rsp_ok_link_ff <= rsp_ok_ff;
      end
    end
  end

  assign RSP_VALID = rsp_valid_ff;
  assign RSP_DATA = rsp_data_link_ff;
  assign RSP_OK = rsp_ok_link_ff;

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      req_meta_ff <= 1'b0;
      req_sync_ff <= 1'b0;
      req_seen_ff <= 1'b0;
      wp_meta_ff <= 1'b1;
      wp_sync_ff <= 1'b1;
    end else begin
      req_meta_ff <= link_req_tgl_ff;
      req_sync_ff <= req_meta_ff;
      req_seen_ff <= req_sync_ff;
      wp_meta_ff <= WP_N;
      wp_sync_ff <= wp_meta_ff;
    end
  end

  logic cmd_new, vol_mode, lock, wr_allowed;
  logic [7:0] status_v;
  logic [2:0] active_bp;

  assign cmd_new = req_sync_ff ^ req_seen_ff;
  assign vol_mode = config_one_nonvolatile_ff[CFG_BIT_PVS];
  // R9 hardware lock
  // R10 pin high unlocks
  // R11 all mapped registers are status/config one
  assign lock = status_one_nonvolatile_ff[BIT_LOCK] && !wp_sync_ff;
  // R21 latch gate
  assign wr_allowed = wel_ff && !wip_ff && !lock;
  // R12 mirrored lock
  assign status_v = {lock_copy_ff, perr_ff, eerr_ff, bp_v_ff, wel_ff, wip_ff};
  // R17 nonvolatile governs
  assign active_bp = vol_mode ? bp_v_ff : status_one_nonvolatile_ff[BP_HI:BP_LO];

  logic [7:0] c_rsp, n_sr1, n_cr1, n_config_one_volatile;
  logic [2:0] n_bpv;
  logic c_ok, do_wren, do_wrdi, do_clear, do_nv;

  // R1 command decode
  always_comb begin
    c_rsp = 8'h00;
    c_ok = 1'b0;
    do_wren = 1'b0;
    do_wrdi = 1'b0;
    do_clear = 1'b0;
    do_nv = 1'b0;
    n_sr1 = status_one_nonvolatile_ff;
    n_cr1 = config_one_nonvolatile_ff;
    n_config_one_volatile = config_one_volatile_ff;
    n_bpv = bp_v_ff;
    case (link_op_ff)
      // R3 volatile read
      CMD_READ_STATUS: begin
        c_rsp = status_v;
        c_ok = 1'b1;
      end
      // R8 generic read
      CMD_GENERIC_READ: begin
        c_ok = 1'b1;
        case (link_addr_ff)
          ADDR_STATUS_ONE_NV: c_rsp = status_one_nonvolatile_ff;
          ADDR_CONFIG_ONE_NV: c_rsp = config_one_nonvolatile_ff;
          ADDR_STATUS_ONE_V: c_rsp = status_v;
          ADDR_CONFIG_ONE_V: c_rsp = config_one_volatile_ff;
          default: c_ok = 1'b0;
        endcase
      end
      CMD_WRITE_ENABLE: begin
        c_ok = !wip_ff;
        do_wren = !wip_ff;
      end
      CMD_WRITE_DISABLE: begin
        c_ok = !wip_ff;
        do_wrdi = !wip_ff;
      end
      CMD_CLEAR_STATUS_A, CMD_CLEAR_STATUS_B: begin
        c_ok = !wip_ff;
        do_clear = !wip_ff;
      end
      // R8 register write
      CMD_REGISTER_WRITE: begin
        if (wr_allowed) begin
          c_ok = 1'b1;
          do_nv = 1'b1;
          n_sr1 = merge_status(status_one_nonvolatile_ff, link_data_ff[7:0], vol_mode);
          if (link_two_ff) begin
            n_cr1 = merge_config(config_one_nonvolatile_ff, link_data_ff[15:8]);
          end
          // R18 volatile-only protect
          if (vol_mode) begin
            n_bpv = link_data_ff[BP_HI:BP_LO];
          end
        end
      end
      // R8 generic write
      CMD_GENERIC_WRITE: begin
        if (wr_allowed) begin
          c_ok = 1'b1;
          case (link_addr_ff)
            ADDR_STATUS_ONE_NV: begin
              do_nv = 1'b1;
              n_sr1 = merge_status(status_one_nonvolatile_ff, link_data_ff[7:0], vol_mode);
            end
            ADDR_CONFIG_ONE_NV: begin
              do_nv = 1'b1;
              n_cr1 = merge_config(config_one_nonvolatile_ff, link_data_ff[7:0]);
            end
            ADDR_STATUS_ONE_V: begin
              if (vol_mode) begin
                n_bpv = link_data_ff[BP_HI:BP_LO];
              end
            end
            ADDR_CONFIG_ONE_V: begin
              n_config_one_volatile = link_data_ff[7:0];
              n_config_one_volatile[CFG_BIT_PVS] = config_one_volatile_ff[CFG_BIT_PVS];
            end
            default: c_ok = 1'b0;
          endcase
        end
      end
      default: c_ok = 1'b0;
    endcase
    // R19 force protect ones
    if (n_cr1[CFG_BIT_PVS]) begin
      n_sr1[BP_HI:BP_LO] = BP_FORCED;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_tgl_ff <= 1'b0;
      rsp_data_ff <= 8'h00;
      rsp_ok_ff <= 1'b0;
    end else if (cmd_new) begin
      ack_tgl_ff <= ~ack_tgl_ff;
      rsp_data_ff <= c_rsp;
      rsp_ok_ff <= c_ok;
    end
  end

  // R5 erase, program, refresh
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      // R7 factory values
      status_one_nonvolatile_ff <= STATUS_ONE_NV_RESET;
      config_one_nonvolatile_ff <= CONFIG_ONE_NV_RESET;
      pend_sr1_ff <= STATUS_ONE_NV_RESET;
      pend_cr1_ff <= CONFIG_ONE_NV_RESET;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (cmd_new && do_nv) begin
            pend_sr1_ff <= n_sr1;
            pend_cr1_ff <= n_cr1;
            cnt_ff <= CNT_W'(ERASE_CYCLES - 1);
            state_ff <= ST_ERASE;
          end
        end
        ST_ERASE: begin
          if (cnt_ff == '0) begin
            status_one_nonvolatile_ff <= NV_ERASED;
            config_one_nonvolatile_ff <= NV_ERASED;
            cnt_ff <= CNT_W'(PROGRAM_CYCLES - 1);
            state_ff <= ST_PROGRAM;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        ST_PROGRAM: begin
          if (cnt_ff == '0) begin
            status_one_nonvolatile_ff <= pend_sr1_ff;
            config_one_nonvolatile_ff <= pend_cr1_ff;
            state_ff <= ST_REFRESH;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        ST_REFRESH: state_ff <= ST_IDLE;
      endcase
    end
  end

  // R23 busy through update
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      wip_ff <= STATUS_ONE_NV_RESET[BIT_BUSY];
    end else if (RESET_REQ) begin
      // an update in flight keeps running, so busy must survive the reload
      wip_ff <= status_one_nonvolatile_ff[BIT_BUSY] || (state_ff != ST_IDLE);
    end else if (cmd_new && do_nv) begin
      wip_ff <= 1'b1;
    end else if (state_ff == ST_REFRESH) begin
      wip_ff <= 1'b0;
    end
  end

  // R21 latch changes
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      wel_ff <= STATUS_ONE_NV_RESET[BIT_WEL];
    end else if (RESET_REQ) begin
      // R15 latch default
      wel_ff <= status_one_nonvolatile_ff[BIT_WEL];
    end else if (cmd_new && do_wren) begin
      wel_ff <= 1'b1;
    end else if (cmd_new && do_wrdi) begin
      wel_ff <= 1'b0;
    end
  end

  logic deny_prog, deny_erase, op_ok;
  // R20 protection check
  assign op_ok = wel_ff && !wip_ff &&
                 ((OP_KIND == OP_CHIP_ERASE) ? (active_bp == BP_NONE) : !OP_IN_REGION);
  assign deny_prog = OP_REQ && !op_ok && (OP_KIND == OP_PROGRAM);
  // a refused chip erase leaves the erase error alone
  assign deny_erase = OP_REQ && !op_ok && (OP_KIND == OP_SECTOR_ERASE);

  // R22 error flags
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      perr_ff <= STATUS_ONE_NV_RESET[BIT_PERR];
      eerr_ff <= STATUS_ONE_NV_RESET[BIT_EERR];
    end else if (RESET_REQ) begin
      // R13 program error default
      perr_ff <= status_one_nonvolatile_ff[BIT_PERR];
      // R14 erase error default
      eerr_ff <= status_one_nonvolatile_ff[BIT_EERR];
    end else begin
      // set wins over a clear in the same cycle
      if (PROG_ERR_EVT || deny_prog) begin
        perr_ff <= 1'b1;
      end else if (cmd_new && do_clear) begin
        perr_ff <= 1'b0;
      end
      if (ERASE_ERR_EVT || deny_erase) begin
        eerr_ff <= 1'b1;
      end else if (cmd_new && do_clear) begin
        eerr_ff <= 1'b0;
      end
    end
  end

  // R2 volatile copies
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      lock_copy_ff <= STATUS_ONE_NV_RESET[BIT_LOCK];
      bp_v_ff <= STATUS_ONE_NV_RESET[BP_HI:BP_LO];
      config_one_volatile_ff <= CONFIG_ONE_NV_RESET;
    end else if (RESET_REQ) begin
      // R4 reload on reset
      lock_copy_ff <= status_one_nonvolatile_ff[BIT_LOCK];
      bp_v_ff <= status_one_nonvolatile_ff[BP_HI:BP_LO];
      config_one_volatile_ff <= config_one_nonvolatile_ff;
    end else if (state_ff == ST_REFRESH) begin
      lock_copy_ff <= status_one_nonvolatile_ff[BIT_LOCK];
      config_one_volatile_ff <= config_one_nonvolatile_ff;
      // R17 copy protect bits
      if (!vol_mode) begin
        bp_v_ff <= status_one_nonvolatile_ff[BP_HI:BP_LO];
      end
    end else if (cmd_new) begin
      bp_v_ff <= n_bpv;
      config_one_volatile_ff <= n_config_one_volatile;
    end
  end

  // R16 protect bits out
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      protect_ff <= STATUS_ONE_NV_RESET[BP_HI:BP_LO];
      grant_ff <= 1'b0;
      deny_ff <= 1'b0;
    end else begin
      protect_ff <= active_bp;
      grant_ff <= OP_REQ && op_ok;
      deny_ff <= OP_REQ && !op_ok;
    end
  end

  assign PROTECT_BITS = protect_ff;
  assign OP_GRANT = grant_ff;
  assign OP_DENY = deny_ff;
  assign BUSY = wip_ff;

endmodule

//--- verif/srbank_properties.sv
/*
  Port checks for srbank_top, bound into every instance after the module.
  Assumes the package constants and the top's count parameters.
*/
`timescale 1ns/1ps
module srbank_chk
  import srbank_pkg::*;
#(
  parameter int ERASE_CYCLES = NV_ERASE_CYCLES,
  parameter int PROGRAM_CYCLES = NV_PROGRAM_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic LINK_CLK,
  input wire logic CMD_STB,
  input wire logic CMD_READY,
  input wire logic RSP_VALID,
  input wire logic OP_REQ,
  input wire logic [1:0] OP_KIND,
  input wire logic OP_IN_REGION,
  input wire logic OP_GRANT,
  input wire logic OP_DENY,
  input wire logic [2:0] PROTECT_BITS,
  input wire logic BUSY
);
  logic [31:0] busy_len_ff;
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_len_ff <= 32'h0;
    end else if (BUSY) begin
      busy_len_ff <= busy_len_ff + 32'h1;
    end else begin
      busy_len_ff <= 32'h0;
    end
  end
  AST_OP_ANSWER: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    OP_REQ |=> OP_GRANT != OP_DENY) else $error("permission answer missing or doubled");
  AST_NO_STRAY: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    !OP_REQ |=> !(OP_GRANT || OP_DENY)) else $error("permission answer without request");
  // protect bits lag by one cycle, so a change right after the request is tolerated
  AST_CHIP_LOCKED: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    OP_REQ && OP_KIND == OP_CHIP_ERASE && PROTECT_BITS != BP_NONE
    |=> OP_DENY || $changed(PROTECT_BITS)) else $error("chip erase granted while protected");
  AST_REGION_DENY: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    OP_REQ && OP_KIND != OP_CHIP_ERASE && OP_IN_REGION |=> OP_DENY)
    else $error("operation granted inside protected region");
  AST_BUSY_DENY: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    OP_REQ && BUSY |=> OP_DENY) else $error("operation granted while busy");
  AST_BUSY_SPAN: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    $fell(BUSY) |-> busy_len_ff >= ERASE_CYCLES + PROGRAM_CYCLES)
    else $error("busy ended before erase and program");
  AST_RSP_PULSE: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
    RSP_VALID |=> !RSP_VALID) else $error("answer pulse longer than one cycle");
  AST_READY_HELD: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
    CMD_STB && CMD_READY |=> !CMD_READY until RSP_VALID)
    else $error("ready rose before the answer");
  AST_ANSWER_TIME: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
    CMD_STB && CMD_READY |-> ##[2:40] RSP_VALID) else $error("command never answered");
  AST_READY_WITH_RSP: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
    RSP_VALID |-> CMD_READY) else $error("ready low during answer");
endmodule

bind srbank_top srbank_chk #(.ERASE_CYCLES(ERASE_CYCLES), .PROGRAM_CYCLES(PROGRAM_CYCLES)) u_chk (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .LINK_CLK(LINK_CLK), .CMD_STB(CMD_STB),
  .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .OP_REQ(OP_REQ), .OP_KIND(OP_KIND),
  .OP_IN_REGION(OP_IN_REGION), .OP_GRANT(OP_GRANT), .OP_DENY(OP_DENY),
  .PROTECT_BITS(PROTECT_BITS), .BUSY(BUSY)
);

//--- verif/srbank_host.sv
/*
  Link-side host model: offers one register command at a time on LINK_CLK.
  Assumes each taken command is answered by one RSP_VALID pulse.
*/
`timescale 1ns/1ps
module srbank_host (
  input wire logic LINK_CLK,
  input wire logic CMD_READY,
  input wire logic RSP_VALID,
  input wire logic [7:0] RSP_DATA,
  input wire logic RSP_OK,
  output logic CMD_STB,
  output logic [7:0] CMD_OP,
  output logic [7:0] CMD_ADDR,
  output logic [15:0] CMD_DATA
);
  initial begin
    CMD_STB = 1'b0;
    CMD_OP = 8'h00;
    CMD_ADDR = 8'h00;
    CMD_DATA = 16'h0000;
  end
  // one dedicated command, held until taken
  task automatic xfer(input logic [7:0] op, input logic [7:0] adr, input logic [15:0] dat,
      input int gap, output logic [7:0] rd, output logic ok, output logic to);
    int n;
    n = 0;
    repeat (gap + 1) @(posedge LINK_CLK);
    CMD_STB <= 1'b1;
    CMD_OP <= op;
    CMD_ADDR <= adr;
    CMD_DATA <= dat;
    do begin
      @(posedge LINK_CLK);
      n++;
    end while (CMD_READY !== 1'b1 && n < 64);
    // released fields carry junk so a stale value is never mistaken for data
    CMD_STB <= 1'b0;
    CMD_OP <= ~op;
    CMD_ADDR <= ~adr;
    CMD_DATA <= ~dat;
    do begin
      @(posedge LINK_CLK);
      n++;
    end while (RSP_VALID !== 1'b1 && n < 128);
    rd = RSP_DATA;
    ok = RSP_OK;
    to = RSP_VALID !== 1'b1;
  endtask
endmodule

//--- verif/srbank_tb.sv
/*
  Self-checking bench for srbank_top with the link host model.
  Assumes short erase and program counts; link clock free of the core clock.
*/
`timescale 1ns/1ps
module testbench;
  import srbank_pkg::*;
  localparam int EC = 64;
  logic CLOCK, LINK_CLK, RESET_N, RESET_REQ, WP_N, CMD_STB, CMD_READY, RSP_VALID, RSP_OK;
  logic OP_REQ, OP_IN_REGION, OP_GRANT, OP_DENY, PROG_ERR_EVT, ERASE_ERR_EVT, BUSY;
  logic [7:0] CMD_OP, CMD_ADDR, RSP_DATA;
  logic [15:0] CMD_DATA;
  logic [1:0] OP_KIND;
  logic [2:0] PROTECT_BITS;
  int n_fail;
  int n_tests;

  srbank_top #(.ERASE_CYCLES(EC), .PROGRAM_CYCLES(EC)) dut (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .RESET_REQ(RESET_REQ), .WP_N(WP_N), .LINK_CLK(LINK_CLK),
    .CMD_STB(CMD_STB), .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR), .CMD_DATA(CMD_DATA),
    .CMD_TWO_BYTES(1'b0), .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
    .RSP_OK(RSP_OK), .OP_REQ(OP_REQ), .OP_KIND(OP_KIND), .OP_IN_REGION(OP_IN_REGION),
    .OP_GRANT(OP_GRANT), .OP_DENY(OP_DENY), .PROG_ERR_EVT(PROG_ERR_EVT),
    .ERASE_ERR_EVT(ERASE_ERR_EVT), .PROTECT_BITS(PROTECT_BITS), .BUSY(BUSY)
  );
  srbank_host host (
    .LINK_CLK(LINK_CLK), .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
    .RSP_OK(RSP_OK), .CMD_STB(CMD_STB), .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR),
    .CMD_DATA(CMD_DATA)
  );

  always #2.5 CLOCK = ~CLOCK;
  always #32 LINK_CLK = ~LINK_CLK;

  task automatic end_sim();
    $display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] adr, input logic [7:0] dat,
      input logic eok, input logic [7:0] erd);
    logic [7:0] rd;
    logic ok;
    logic to;
    host.xfer(op, adr, {8'h00, dat}, int'(op[1:0]), rd, ok, to);
    if (to) begin
      n_fail++;
      end_sim();
    end
    chk({7'h00, ok}, {7'h00, eok});
    chk(rd, erd);
  endtask

  task automatic idle();
    int n;
    n = 0;
    while (BUSY !== 1'b0 && n < 4000) begin
      @(posedge CLOCK);
      n++;
    end
    if (n >= 4000) begin
      n_fail++;
      end_sim();
    end
  endtask

  task automatic opr(input logic [1:0] k, input logic r, input logic g);
    @(posedge CLOCK);
    OP_REQ <= 1'b1;
    OP_KIND <= k;
    OP_IN_REGION <= r;
    @(posedge CLOCK);
    OP_REQ <= 1'b0;
    #1;
    chk({6'h00, OP_GRANT, OP_DENY}, {6'h00, g, ~g});
  endtask

  task automatic evt(input logic prog);
    @(posedge CLOCK);
    PROG_ERR_EVT <= prog;
    ERASE_ERR_EVT <= ~prog;
    @(posedge CLOCK);
    PROG_ERR_EVT <= 1'b0;
    ERASE_ERR_EVT <= 1'b0;
  endtask

  task automatic t_defaults();
    cmd(CMD_READ_STATUS, 8'h00, 8'h00, 1'b1, 8'h00);
    cmd(CMD_GENERIC_READ, ADDR_STATUS_ONE_NV, 8'h00, 1'b1, STATUS_ONE_NV_RESET);
    cmd(CMD_GENERIC_READ, 8'h55, 8'h00, 1'b0, 8'h00);
    cmd(8'h9F, 8'h00, 8'h00, 1'b0, 8'h00);
    cmd(CMD_REGISTER_WRITE, 8'h00, 8'h1C, 1'b0, 8'h00);
  endtask

  task automatic t_nv_write();
    cmd(CMD_WRITE_ENABLE, 8'h00, 8'h00, 1'b1, 8'h00);
    evt(1'b0);
    cmd(CMD_REGISTER_WRITE, 8'h00, 8'h7F, 1'b1, 8'h00);
    chk({7'h00, BUSY}, 8'h01);
    opr(OP_PROGRAM, 1'b0, 1'b0);
    idle();
    cmd(CMD_READ_STATUS, 8'h00, 8'h00, 1'b1, 8'h7E);
    cmd(CMD_GENERIC_READ, ADDR_STATUS_ONE_NV, 8'h00, 1'b1, 8'h1C);
    chk({5'h00, PROTECT_BITS}, 8'h07);
  endtask

  task automatic t_array();
    opr(OP_CHIP_ERASE, 1'b0, 1'b0);
    opr(OP_SECTOR_ERASE, 1'b0, 1'b1);
    opr(OP_SECTOR_ERASE, 1'b1, 1'b0);
    evt(1'b1);
    cmd(CMD_CLEAR_STATUS_A, 8'h00, 8'h00, 1'b1, 8'h00);
    cmd(CMD_READ_STATUS, 8'h00, 8'h00, 1'b1, 8'h1E);
  endtask

  task automatic t_lock();
    cmd(CMD_REGISTER_WRITE, 8'h00, 8'h80, 1'b1, 8'h00);
    idle();
    cmd(CMD_READ_STATUS, 8'h00, 8'h00, 1'b1, 8'h82);
    WP_N <= 1'b0;
    repeat (4) @(posedge CLOCK);
    cmd(CMD_REGISTER_WRITE, 8'h00, 8'h00, 1'b0, 8'h00);
    cmd(CMD_GENERIC_WRITE, ADDR_CONFIG_ONE_NV, 8'h08, 1'b0, 8'h00);
    WP_N <= 1'b1;
    repeat (4) @(posedge CLOCK);
    cmd(CMD_REGISTER_WRITE, 8'h00, 8'h00, 1'b1, 8'h00);
    idle();
    cmd(CMD_READ_STATUS, 8'h00, 8'h00, 1'b1, 8'h02);
    cmd(CMD_WRITE_DISABLE, 8'h00, 8'h00, 1'b1, 8'h00);
    cmd(CMD_REGISTER_WRITE, 8'h00, 8'h00, 1'b0, 8'h00);
    cmd(CMD_WRITE_ENABLE, 8'h00, 8'h00, 1'b1, 8'h00);
  endtask

  task automatic t_volatile();
    cmd(CMD_GENERIC_WRITE, ADDR_CONFIG_ONE_NV, 8'h08, 1'b1, 8'h00);
    idle();
    cmd(CMD_GENERIC_READ, ADDR_STATUS_ONE_NV, 8'h00, 1'b1, 8'h1C);
    cmd(CMD_REGISTER_WRITE, 8'h00, 8'h04, 1'b1, 8'h00);
    idle();
    cmd(CMD_READ_STATUS, 8'h00, 8'h00, 1'b1, 8'h06);
    cmd(CMD_GENERIC_READ, ADDR_STATUS_ONE_NV, 8'h00, 1'b1, 8'h1C);
    chk({5'h00, PROTECT_BITS}, 8'h01);
    cmd(CMD_CLEAR_STATUS_B, 8'h00, 8'h00, 1'b1, 8'h00);
    @(posedge CLOCK);
    RESET_REQ <= 1'b1;
    @(posedge CLOCK);
    RESET_REQ <= 1'b0;
    cmd(CMD_READ_STATUS, 8'h00, 8'h00, 1'b1, 8'h1C);
    cmd(CMD_GENERIC_READ, ADDR_STATUS_ONE_V, 8'h00, 1'b1, 8'h1C);
    cmd(CMD_GENERIC_READ, ADDR_CONFIG_ONE_V, 8'h00, 1'b1, 8'h08);
  endtask

  initial begin
    CLOCK = 1'b0;
    LINK_CLK = 1'b0;
    RESET_N = 1'b0;
    RESET_REQ = 1'b0;
    WP_N = 1'b1;
    OP_REQ = 1'b0;
    OP_KIND = OP_PROGRAM;
    OP_IN_REGION = 1'b0;
    PROG_ERR_EVT = 1'b0;
    ERASE_ERR_EVT = 1'b0;
    n_fail = 0;
    n_tests = 0;
    // the link side needs one of its own edges inside reset
    @(posedge LINK_CLK);
    repeat (3) @(posedge CLOCK);
    RESET_N <= 1'b1;
    repeat (4) @(posedge LINK_CLK);
    t_defaults();
    t_nv_write();
    t_array();
    t_lock();
    t_volatile();
    end_sim();
  end
endmodule
